// >>> flash_bus_host.sv
// Functional notes
// - Identifier and status reads are reached by commands, any supply level.
// - Host enables valid program supply before issuing program or erase.
// - Array is unreadable during program or erase, except during suspend.
// - Reads drive select and output enable low, write strobe high.
// - Byte mode uses eight low pins; top pin is lowest address bit.
// - After wake, host waits read delay and longer write delay.
// - After abort, shutdown time passes before wake delays begin.
// - Power-down input follows the system reset; here reset asserts it and it stays asserted until software releases it.
// - Writes use select and write strobe low, output enable high.
`include "flash_ctrl_map.svh"

module flash_bus_host (
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hsel,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic      [19:0]            flashAddr,
  output logic                        byteSelectAddress,
  output logic                        chipSelectN,
  output logic                        outputEnableN,
  output logic                        writeEnableN,
  output logic                        powerDownResetN,
  output logic                        byteModeN,
  output logic                        vppEnable,
  output logic                        identifierHighVoltage,
  output logic      [14:0]            dqOut,
  output logic                        dqLowOe,
  output logic                        dqHighOe,
  input  wire logic [14:0]            dqIn
);
  import flash_ctrl_pkg::*;

  // ---------------------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------------------
  logic [7:0]  ctrl_q, ctrl_d;
  logic [20:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic        done_q, done_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        wrPend_q, wrPend_d;
  logic [7:0]  wrAddr_q, wrAddr_d;
  bus_state_t  state_q, state_d;
  count_t      cnt_q, cnt_d;
  count_t      wakeR_q, wakeR_d;
  count_t      wakeW_q, wakeW_d;
  logic        opWrite_q, opWrite_d;
  logic        ceN_q, ceN_d, oeN_q, oeN_d, weN_q, weN_d, pdN_q, pdN_d;
  logic        oeL_q, oeL_d, oeH_q, oeH_d;
  logic        go, wantPd, isByte;
  logic        pdHeld, widthSet;
  logic        wakeOk, opBusy;

  assign wantPd = ctrl_q[`CTRL_PD_BIT];
  assign isByte = ~ctrl_q[`CTRL_BYTE_BIT];

  // ---------------------------------------------------------------------------
  // Power-down and wake gating.
  // ---------------------------------------------------------------------------
  // The power-down pulse has run its minimum low time.
  assign pdHeld   = cnt_q <= 16'(`CYC_SHUTDOWN - `CYC_PD_LOW);
  // The width select has settled before the device wakes.
  assign widthSet = byteModeN == ctrl_q[`CTRL_BYTE_BIT];
  // An access waits out the wake delay of its own kind, taken from the new control value.
  assign wakeOk   = ctrl_d[`CTRL_WRITE_BIT] ? (wakeW_q == 16'h0000) : (wakeR_q == 16'h0000);
  // Software polls busy and reads the array only once idle.
  assign opBusy   = state_q != ST_IDLE;

  // ---------------------------------------------------------------------------
  // AHB-Lite slave, zero wait states.
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_d   = ctrl_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    hrdata_d = hrdata_q;
    wrPend_d = 1'b0;
    wrAddr_d = wrAddr_q;
    go       = 1'b0;
    if (wrPend_q) begin
      unique case (wrAddr_q)
        `REG_CTRL: begin
          ctrl_d = hwdata[7:0];
          ctrl_d[`CTRL_GO_BIT] = 1'b0;
          go = hwdata[`CTRL_GO_BIT];
        end
        `REG_ADDR: addr_d = hwdata[20:0];
        `REG_WDATA: wdata_d = hwdata[15:0];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      wrPend_d = hwrite;
      wrAddr_d = haddr[7:0];
      unique case (haddr[7:0])
        `REG_CTRL:   hrdata_d = {24'h000000, ctrl_q};
        `REG_ADDR:   hrdata_d = {11'h000, addr_q};
        `REG_WDATA:  hrdata_d = {16'h0000, wdata_q};
        `REG_STATUS: hrdata_d = {28'h0000000, (wakeW_q != 16'h0000), ~pdN_q, done_q, opBusy};
        `REG_RDATA:  hrdata_d = {16'h0000, rdata_q};
        default:     hrdata_d = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Flash bus sequencer.
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    wakeR_d   = (wakeR_q != 16'h0000) ? wakeR_q - 16'h0001 : wakeR_q;
    wakeW_d   = (wakeW_q != 16'h0000) ? wakeW_q - 16'h0001 : wakeW_q;
    opWrite_d = opWrite_q;
    ceN_d     = ceN_q;
    oeN_d     = oeN_q;
    weN_d     = weN_q;
    pdN_d     = pdN_q;
    oeL_d     = oeL_q;
    oeH_d     = oeH_q;
    rdata_d   = rdata_q;
    done_d    = done_q;
    if (go) begin
      done_d = 1'b0;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (wantPd) begin
          // Power-down aborts any running device operation and is held its pulse time.
          pdN_d   = 1'b0;
          ceN_d   = 1'b1;
          state_d = ST_PD;
          cnt_d   = 16'(`CYC_SHUTDOWN);
        end else if (go && wakeOk) begin
          // The wake delays gate the start of each access.
          opWrite_d = ctrl_d[`CTRL_WRITE_BIT];
          ceN_d     = 1'b0;
          state_d   = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (opWrite_q) begin
          // Command writes drive data with output enable high.
          oeL_d = 1'b1;
          oeH_d = ~isByte;
          weN_d = 1'b0;
          cnt_d = 16'(`CYC_WRITE_PULSE);
        end else begin
          // Reads drop output enable with the write strobe held high.
          oeN_d = 1'b0;
          cnt_d = 16'(`CYC_ACCESS);
        end
        state_d = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt_q > 16'h0001) begin
          cnt_d = cnt_q - 16'h0001;
        end else begin
          if (!opWrite_q) begin
            // Byte mode takes the low eight pins only.
            rdata_d = isByte ? {8'h00, dqIn[7:0]} : {byteSelectAddress, dqIn};
          end
          weN_d   = 1'b1;
          oeN_d   = 1'b1;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Data stays driven one cycle after the write strobe rises.
        oeL_d   = 1'b0;
        oeH_d   = 1'b0;
        ceN_d   = 1'b1;
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      ST_PD: begin
        if (cnt_q != 16'h0000) begin
          cnt_d = cnt_q - 16'h0001;
        end
        if (!wantPd && pdHeld && widthSet) begin
          // Wake delays count from the later of release and shutdown end.
          pdN_d   = 1'b1;
          wakeR_d = cnt_q + 16'(`CYC_WAKE_READ);
          wakeW_d = cnt_q + 16'(`CYC_WAKE_WRITE);
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q    <= `CTRL_RESET;
      addr_q    <= 21'h000000;
      wdata_q   <= 16'h0000;
      rdata_q   <= 16'h0000;
      done_q    <= 1'b0;
      hrdata_q  <= 32'h00000000;
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      state_q   <= ST_PD;
      cnt_q     <= 16'(`CYC_SHUTDOWN);
      wakeR_q   <= 16'h0000;
      wakeW_q   <= 16'h0000;
      opWrite_q <= 1'b0;
      ceN_q     <= 1'b1;
      oeN_q     <= 1'b1;
      weN_q     <= 1'b1;
      // System reset holds the device in power-down until software releases it.
      pdN_q     <= 1'b0;
      oeL_q     <= 1'b0;
      oeH_q     <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      rdata_q   <= rdata_d;
      done_q    <= done_d;
      hrdata_q  <= hrdata_d;
      wrPend_q  <= wrPend_d;
      wrAddr_q  <= wrAddr_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      wakeR_q   <= wakeR_d;
      wakeW_q   <= wakeW_d;
      opWrite_q <= opWrite_d;
      ceN_q     <= ceN_d;
      oeN_q     <= oeN_d;
      weN_q     <= weN_d;
      pdN_q     <= pdN_d;
      oeL_q     <= oeL_d;
      oeH_q     <= oeH_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Output pins.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flashAddr             <= 20'h00000;
      byteSelectAddress     <= 1'b0;
      byteModeN             <= 1'b0;
      vppEnable             <= 1'b0;
      identifierHighVoltage <= 1'b0;
      dqOut                 <= 15'h0000;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
    end else begin
      flashAddr             <= addr_q[20:1];
      // The top data pin carries the lowest address bit in byte mode.
      byteSelectAddress     <= isByte ? addr_q[0] : wdata_q[15];
      byteModeN             <= ctrl_q[`CTRL_BYTE_BIT];
      // Program supply is raised only on software request.
      vppEnable             <= ctrl_q[`CTRL_VPP_BIT];
      identifierHighVoltage <= ctrl_q[`CTRL_IDHV_BIT];
      dqOut                 <= wdata_q[14:0];
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
    end
  end

  assign hrdata          = hrdata_q;
  assign chipSelectN     = ceN_q;
  assign outputEnableN   = oeN_q;
  assign writeEnableN    = weN_q;
  assign powerDownResetN = pdN_q;
  assign dqLowOe         = oeL_q;
  assign dqHighOe        = oeH_q;
endmodule : flash_bus_host

// >>> flash_bus_host_checker.sv
module flash_bus_host_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [19:0] flashAddr,
  input wire logic        chipSelectN,
  input wire logic        outputEnableN,
  input wire logic        writeEnableN,
  input wire logic        powerDownResetN,
  input wire logic        byteModeN,
  input wire logic [14:0] dqOut,
  input wire logic        dqLowOe,
  input wire logic        dqHighOe
);
  logic [7:0] wakeCnt_q, wakeCnt_d;
  always_comb wakeCnt_d = !powerDownResetN ? 8'h00 : wakeCnt_q + {7'h00, wakeCnt_q != 8'hFF};
  always_ff @(posedge sys_clk) wakeCnt_q <= srst ? 8'h00 : wakeCnt_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence strobeHeld;
    ##1 (writeEnableN && !chipSelectN && $stable(flashAddr) && $stable(dqOut));
  endsequence
  read_ctl_a: assert property (!outputEnableN |-> !chipSelectN && writeEnableN && powerDownResetN)
    else $error("read strobe misqualified");
  write_ctl_a: assert property (!writeEnableN |-> !chipSelectN && outputEnableN && dqLowOe)
    else $error("write strobe misqualified");
  write_hold_a: assert property ($fell(writeEnableN) |-> strobeHeld)
    else $error("write pulse not held");
  reset_pd_a: assert property (@(posedge sys_clk) disable iff (1'b0) srst |=> !powerDownResetN)
    else $error("power-down not asserted in reset");
  byte_float_a: assert property (!byteModeN |-> !dqHighOe)
    else $error("upper lane driven in byte mode");
  no_clash_a: assert property (!outputEnableN |-> !dqLowOe && !dqHighOe)
    else $error("data driven during read");
  wake_read_a: assert property ($rose(powerDownResetN) |-> outputEnableN [*5])
    else $error("read too soon after wake");
  wake_write_a: assert property ($fell(writeEnableN) |-> wakeCnt_q >= 8'h0A)
    else $error("write too soon after wake");
endmodule : flash_bus_host_checker

bind flash_bus_host flash_bus_host_checker chk (.sys_clk, .srst, .flashAddr, .chipSelectN, .outputEnableN,
  .writeEnableN, .powerDownResetN, .byteModeN, .dqOut, .dqLowOe, .dqHighOe);

// >>> flash_bus_host_test.sv
`include "flash_ctrl_map.svh"
`define CHECK(g, e) begin numChecks++; if ((g) !== (e)) begin badCount++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end

module flash_bus_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, srst = 1'b1, hwrite = 1'b0, hreadyout;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ctrl = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [19:0] flashAddr;
  logic [14:0] dqOut, dqIn, devDq;
  logic        byteSelectAddress, chipSelectN, outputEnableN, writeEnableN, powerDownResetN;
  logic        byteModeN, vppEnable, identifierHighVoltage, dqLowOe, dqHighOe, devLowOe, devHighOe;
  int          badCount = 0, numChecks = 0, cyc = 0;
  assign dqIn[7:0] = devLowOe ? devDq[7:0] : dqLowOe ? dqOut[7:0] : ~devDq[7:0];
  assign dqIn[14:8] = devHighOe ? devDq[14:8] : dqHighOe ? dqOut[14:8] : ~devDq[14:8];
  flash_bus_host uut (.sys_clk, .srst, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hsel(1'b1),
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .flashAddr, .byteSelectAddress, .chipSelectN,
    .outputEnableN, .writeEnableN, .powerDownResetN, .byteModeN, .vppEnable, .identifierHighVoltage,
    .dqOut, .dqLowOe, .dqHighOe, .dqIn);
  flash_device_model #(.PROG_CYC(200)) dev (.sys_clk, .flashAddr, .byteSelectAddress, .chipSelectN,
    .outputEnableN, .writeEnableN, .powerDownResetN, .byteModeN, .vppEnable, .identifierHighVoltage,
    .dqOut, .devDq, .devLowOe, .devHighOe);
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      summarize();
    end
  end
  task automatic summarize();
    if (badCount == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic setCtrl(input logic [31:0] c);
    logic [31:0] t;
    ctrl = c;
    ahb(1'b1, `REG_CTRL, c, t);
    if (!c[`CTRL_PD_BIT]) for (int n = 0; n < 300; n++) begin
      ahb(1'b0, `REG_STATUS, 32'h0, t);
      if (t[3:2] === 2'h0) break;
    end
  endtask : setCtrl
  task automatic op(input logic w, input logic [20:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [31:0] t;
    ahb(1'b1, `REG_ADDR, {11'h0, a}, t);
    ahb(1'b1, `REG_WDATA, {16'h0, d}, t);
    ahb(1'b1, `REG_CTRL, ctrl | {30'h0, w, 1'b1}, t);
    for (int n = 0; n < 50; n++) begin
      ahb(1'b0, `REG_STATUS, 32'h0, t);
      if (t[`STAT_DONE_BIT] === 1'b1) break;
    end
    `CHECK(t[`STAT_DONE_BIT], 1'b1)
    ahb(1'b0, `REG_RDATA, 32'h0, t);
    r = t[15:0];
  endtask : op
  task automatic programWord();
    logic [15:0] r;
    setCtrl(32'h18);
    op(1'b0, 21'h6, 16'h0, r);
    `CHECK(r[14:0], 15'h2503)
    op(1'b1, 21'h14, 16'h0040, r);
    op(1'b1, 21'h14, 16'h1234, r);
    op(1'b0, 21'h14, 16'h0, r);
    `CHECK(r[14:0], 15'h0000)
    op(1'b1, 21'h0, 16'h00FF, r);
    op(1'b0, 21'h14, 16'h0, r);
    `CHECK(r[14:0], 15'h0000)
    repeat (250) @(posedge sys_clk);
    op(1'b0, 21'h14, 16'h0, r);
    `CHECK(r[7:0], 8'h80)
    op(1'b1, 21'h0, 16'h00FF, r);
    op(1'b0, 21'h14, 16'h0, r);
    `CHECK(r[14:0], 15'h1234)
  endtask : programWord
  task automatic identify();
    logic [15:0] r;
    op(1'b1, 21'h0, 16'h0090, r);
    op(1'b0, 21'h0, 16'h0, r);
    `CHECK(r[7:0], 8'h5A)
    op(1'b0, 21'h2, 16'h0, r);
    `CHECK(r[7:0], 8'hC3)
    op(1'b1, 21'h0, 16'h00FF, r);
    setCtrl(32'h38);
    op(1'b0, 21'h2, 16'h0, r);
    `CHECK(r[7:0], 8'hC3)
    setCtrl(32'h18);
  endtask : identify
  task automatic byteMode();
    logic [15:0] r;
    setCtrl(32'h1C);
    setCtrl(32'h08);
    op(1'b0, 21'h7, 16'h0, r);
    `CHECK(r[7:0], 8'hA5)
    op(1'b0, 21'h6, 16'h0, r);
    `CHECK(r[7:0], 8'h03)
    setCtrl(32'h0C);
    setCtrl(32'h18);
  endtask : byteMode
  task automatic abortProgram();
    logic [15:0] r;
    op(1'b1, 21'h20, 16'h0040, r);
    op(1'b1, 21'h20, 16'h5555, r);
    setCtrl(32'h1C);
    setCtrl(32'h18);
    op(1'b0, 21'h20, 16'h0, r);
    `CHECK(r[14:0], 15'h2AAA)
    op(1'b1, 21'h0, 16'h0070, r);
    op(1'b0, 21'h0, 16'h0, r);
    `CHECK(r[7:0], 8'h80)
  endtask : abortProgram
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    programWord();
    identify();
    byteMode();
    abortProgram();
    summarize();
  end
endmodule : flash_bus_host_test

// >>> flash_ctrl_map.svh
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

// -----------------------------------------------------------------------------
// Register offsets of the controller.
// -----------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0C
`define REG_RDATA       8'h10

// -----------------------------------------------------------------------------
// Control register fields.
// -----------------------------------------------------------------------------
`define CTRL_GO_BIT     0
`define CTRL_WRITE_BIT  1
`define CTRL_PD_BIT     2
`define CTRL_VPP_BIT    3
`define CTRL_BYTE_BIT   4
`define CTRL_IDHV_BIT   5
`define CTRL_RESET      8'h04

// -----------------------------------------------------------------------------
// Status register fields.
// -----------------------------------------------------------------------------
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_PD_BIT     2
`define STAT_WAKE_BIT   3

// -----------------------------------------------------------------------------
// Device command codes and block sizes.
// -----------------------------------------------------------------------------
`define CMD_READ_ARRAY  16'h00FF
`define STATUS_AT_WAKE  8'h80
`define MAIN_BLOCK_FIRST 32'h00018000
`define MAIN_BLOCK_NEXT  32'h00020000

// -----------------------------------------------------------------------------
// Timing in nanoseconds and in cycles of a 100 ns clock.
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define T_PD_LOW_NS     100
`define T_WAKE_READ_NS  450
`define T_WAKE_WRITE_NS 1000
`define T_SHUTDOWN_NS   22000
`define T_ACCESS_NS     100
`define T_WRITE_PULSE_NS 100
`define CYC_PD_LOW      ((`T_PD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WAKE_READ   ((`T_WAKE_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WAKE_WRITE  ((`T_WAKE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SHUTDOWN    ((`T_SHUTDOWN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ACCESS      ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WRITE_PULSE ((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> flash_ctrl_pkg.sv
package flash_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_PD
  } bus_state_t;
  typedef logic [15:0] count_t;
endpackage : flash_ctrl_pkg

// >>> flash_device_model.sv
module flash_device_model #(
  parameter int         PROG_CYC = 200,
  parameter logic [7:0] MFR_ID   = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEV_ID   = 8'hC3, // Arbitrary value.
  parameter logic [7:0] CMD_STAT = 8'h70,
  parameter logic [7:0] CMD_PROG = 8'h40,
  parameter int         EXTRA_MAIN = 7,
  parameter bit         TOP_BOOT   = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic [19:0] flashAddr,
  input  wire logic        byteSelectAddress,
  input  wire logic        chipSelectN,
  input  wire logic        outputEnableN,
  input  wire logic        writeEnableN,
  input  wire logic        powerDownResetN,
  input  wire logic        byteModeN,
  input  wire logic        vppEnable,
  input  wire logic        identifierHighVoltage,
  input  wire logic [14:0] dqOut,
  output logic      [14:0] devDq,
  output logic             devLowOe,
  output logic             devHighOe
);
  logic [15:0] mem [256];
  logic [15:0] rd, pData;
  logic [7:0]  stat, pAddr, cmd;
  logic [1:0]  mode = 2'd0;
  logic        arm = 1'b0, wide = 1'b1;
  int          busy = 0;
  localparam int MAIN_BYTES = 98304 + 131072 * EXTRA_MAIN;
  initial begin
    stat = 8'h80;
    for (int i = 0; i < 256; i++) mem[i] = {8'hA5, i[7:0]};
  end
  always @(posedge writeEnableN) if (!chipSelectN && powerDownResetN && busy == 0) begin
    cmd = dqOut[7:0];
    if (arm) begin
      arm = 1'b0;
      mode = 2'd2;
      stat = vppEnable ? 8'h00 : 8'h88;
      busy = vppEnable ? PROG_CYC : 0;
      pAddr = flashAddr[7:0];
      pData = {byteSelectAddress, dqOut};
    end
    else if (cmd == 8'hFF) mode = 2'd0;
    else if (cmd == 8'h90) mode = 2'd1;
    else if (cmd == CMD_STAT) mode = 2'd2;
    else if (cmd == CMD_PROG) arm = 1'b1;
  end
  always @(posedge sys_clk) if (busy > 0 && powerDownResetN) begin
    busy--;
    if (busy == 0) begin
      mem[pAddr] = pData;
      stat = 8'h80;
    end
  end
  always @(negedge powerDownResetN) begin
    if (busy > 0) mem[pAddr] = ~pData;
    busy = 0;
    arm = 1'b0;
  end
  always @(posedge powerDownResetN) begin
    mode = 2'd0;
    stat = 8'h80;
    wide = byteModeN;
  end
  always_comb begin
    if (identifierHighVoltage || mode == 2'd1) rd = {8'h00, flashAddr[0] ? DEV_ID + {7'h00, !TOP_BOOT} : MFR_ID};
    else if (mode == 2'd2) rd = {8'h00, stat};
    else if (wide) rd = mem[flashAddr[7:0]];
    else rd = {8'h00, byteSelectAddress ? mem[flashAddr[7:0]][15:8] : mem[flashAddr[7:0]][7:0]};
  end
  assign devDq = rd[14:0];
  assign devLowOe = powerDownResetN && !chipSelectN && !outputEnableN;
  assign devHighOe = devLowOe && wide;
endmodule : flash_device_model
